// ### rss_pkg.sv
// Constants, register map and selector codes of the relay status selector
package rss_pkg;

    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] RSS_REG_CTRL = 8'h00;
    localparam logic [7:0] RSS_REG_OFS = 8'h04;
    localparam logic [7:0] RSS_REG_SCALE = 8'h08;
    localparam logic [7:0] RSS_REG_THR = 8'h0c;
    localparam logic [7:0] RSS_REG_HYS = 8'h10;
    localparam logic [7:0] RSS_REG_MIN = 8'h14;
    localparam logic [7:0] RSS_REG_MAX = 8'h18;
    localparam logic [7:0] RSS_REG_STAT = 8'h1c;
    localparam logic [7:0] RSS_REG_AIN1 = 8'h20;
    localparam logic [7:0] RSS_REG_DEM = 8'h24;

    // ==========================================================
    // Field layout
    localparam int RSS_FUNC_LSB = 0;
    localparam int RSS_SRC_LSB = 4;
    localparam int RSS_CW_RELAY_BIT = 8;
    localparam int RSS_ST_RELAY = 0;
    localparam int RSS_ST_COND = 1;
    localparam int RSS_ST_HI = 2;
    localparam int RSS_ST_LO = 5;

    // ==========================================================
    // Relay function codes
    typedef enum logic [3:0] {
        RSS_F_RUN = 4'h0,
        RSS_F_HEALTHY = 4'h1,
        RSS_F_AT_SPD = 4'h2,
        RSS_F_TRIP = 4'h3,
        RSS_F_SPD_HI = 4'h4,
        RSS_F_CUR_HI = 4'h5,
        RSS_F_SPD_LO = 4'h6,
        RSS_F_CUR_LO = 4'h7,
        RSS_F_AIN2_HI = 4'h8,
        RSS_F_READY = 4'h9,
        RSS_F_FIRE = 4'ha,
        RSS_F_SPD_NF = 4'hb,
        RSS_F_BUS = 4'hc
    } rss_func_t;
    localparam logic [3:0] RSS_SRC_SLAVE = 4'h9;
    localparam logic [3:0] RSS_SRC_RST = 4'h0;

    // ==========================================================
    // Settings in units of 0.1 percent
    localparam logic signed [35:0] RSS_PCT_DIV = 36'sh0000003e8;
    localparam logic signed [15:0] RSS_OFS_MIN = -16'sh1388;
    localparam logic signed [15:0] RSS_OFS_MAX = 16'sh1388;
    localparam logic signed [15:0] RSS_OFS_RST = 16'sh0000;
    localparam logic [15:0] RSS_SCALE_RST = 16'h03e8;
    localparam logic [15:0] RSS_THR_MAX = 16'h07d0;
    localparam logic [15:0] RSS_THR_RST = 16'h03e8;
    localparam logic [15:0] RSS_HYS_MAX = 16'h03e8;
    localparam logic [15:0] RSS_HYS_RST = 16'h0000;
    localparam logic signed [15:0] RSS_MIN_RST = 16'sh0000;
    localparam logic signed [15:0] RSS_MAX_RST = 16'sh03e8;

endpackage : rss_pkg

// ### rss_relay_status_selector.sv
// Relay status selector with analog input conditioning and slave scaling
`timescale 1ns/1ns
`default_nettype none

module rss_relay_status_selector
    import rss_pkg::*;
(
    input wire logic I_CLK,
    input wire logic I_ARST_N,
    input wire logic [7:0] I_AVS_ADDRESS,
    input wire logic I_AVS_READ,
    input wire logic I_AVS_WRITE,
    input wire logic [31:0] I_AVS_WRITEDATA,
    output logic [31:0] O_AVS_READDATA,
    output logic O_AVS_WAITREQUEST,
    input wire logic [15:0] I_AIN1_LEVEL,
    input wire logic [15:0] I_AIN2_LEVEL,
    input wire logic [15:0] I_OUT_FREQ,
    input wire logic [15:0] I_SETPOINT_FREQ,
    input wire logic [15:0] I_MOTOR_CURRENT,
    input wire logic [15:0] I_MASTER_SPEED,
    input wire logic [15:0] I_CTRL_WORD,
    input wire logic I_RUNNING,
    input wire logic I_FAULT,
    input wire logic I_READY,
    input wire logic I_FIRE_MODE,
    output logic O_RELAY,
    output logic [15:0] O_AIN1_VALUE,
    output logic [15:0] O_SPEED_DEMAND
);

    localparam logic signed [15:0] RSS_MAX_POS = 16'sh7fff;
    localparam logic signed [15:0] RSS_MIN_NEG = -16'sh8000;

    // ==========================================================
    // Functions
    function automatic logic signed [15:0] scale_sat(
        input logic signed [17:0] v,
        input logic [15:0] f
    );
        logic signed [35:0] p;
        p = 36'(v * $signed({2'b00, f})) / RSS_PCT_DIV;
        if (p > 36'(RSS_MAX_POS))
            scale_sat = RSS_MAX_POS;
        else if (p < 36'(RSS_MIN_NEG))
            scale_sat = RSS_MIN_NEG;
        else
            scale_sat = p[15:0];
    endfunction : scale_sat

    function automatic logic signed [15:0] clamp(
        input logic signed [15:0] x,
        input logic signed [15:0] lo,
        input logic signed [15:0] hi
    );
        if (x > hi)
            clamp = hi;
        else if (x < lo)
            clamp = lo;
        else
            clamp = x;
    endfunction : clamp

    // Hysteresis keeps the flag set until the value falls below thr - hys
    function automatic logic upd_hi(
        input logic cur,
        input logic [15:0] q,
        input logic [15:0] thr,
        input logic [15:0] hys
    );
        logic [16:0] qx;
        qx = {1'b0, q} + {1'b0, hys};
        upd_hi = (q >= thr) | (cur & (qx >= {1'b0, thr}));
    endfunction : upd_hi

    function automatic logic upd_lo(
        input logic cur,
        input logic [15:0] q,
        input logic [15:0] thr,
        input logic [15:0] hys
    );
        logic [16:0] tx;
        tx = {1'b0, thr} + {1'b0, hys};
        upd_lo = (q < thr) | (cur & ({1'b0, q} < tx));
    endfunction : upd_lo

    // ==========================================================
    // Reset release
    logic rst_ff1;
    logic rst_n;

    always_ff @(posedge I_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
        begin
            rst_ff1 <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_ff1 <= 1'b1;
            rst_n <= rst_ff1;
        end
    end

    // ==========================================================
    // Settings registers
    rss_func_t func;
    logic [3:0] src;
    logic signed [15:0] ofs;
    logic [15:0] scale;
    logic [15:0] thr;
    logic [15:0] hys;
    logic signed [15:0] spd_min;
    logic signed [15:0] spd_max;
    logic ack;

    // One wait cycle per access; write lands at the edge it is released
    wire bus_req = I_AVS_READ | I_AVS_WRITE;
    wire wr_go = I_AVS_WRITE & ack;
    wire [15:0] wd = I_AVS_WRITEDATA[15:0];
    wire [3:0] wd_func = I_AVS_WRITEDATA[RSS_FUNC_LSB +: 4];
    wire [3:0] wd_src = I_AVS_WRITEDATA[RSS_SRC_LSB +: 4];
    wire wr_ctrl = wr_go & (I_AVS_ADDRESS == RSS_REG_CTRL);
    wire wr_ofs = wr_go & (I_AVS_ADDRESS == RSS_REG_OFS);
    wire wr_scale = wr_go & (I_AVS_ADDRESS == RSS_REG_SCALE);
    wire wr_thr = wr_go & (I_AVS_ADDRESS == RSS_REG_THR);
    wire wr_hys = wr_go & (I_AVS_ADDRESS == RSS_REG_HYS);
    wire wr_min = wr_go & (I_AVS_ADDRESS == RSS_REG_MIN);
    wire wr_max = wr_go & (I_AVS_ADDRESS == RSS_REG_MAX);
    // Out-of-range values are dropped so the setting keeps its last legal value
    wire func_ok = wd_func <= RSS_F_BUS;
    wire ofs_ok = ($signed(wd) >= RSS_OFS_MIN) && ($signed(wd) <= RSS_OFS_MAX);
    wire thr_ok = wd <= RSS_THR_MAX;
    wire hys_ok = wd <= RSS_HYS_MAX;

    assign O_AVS_WAITREQUEST = bus_req & ~ack;

    always_ff @(posedge I_CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ack <= 1'b0;
            func <= RSS_F_HEALTHY;
            src <= RSS_SRC_RST;
            ofs <= RSS_OFS_RST;
            scale <= RSS_SCALE_RST;
            thr <= RSS_THR_RST;
            hys <= RSS_HYS_RST;
            spd_min <= RSS_MIN_RST;
            spd_max <= RSS_MAX_RST;
        end
        else
        begin
            ack <= bus_req & ~ack;
            if (wr_ctrl && func_ok)
                func <= rss_func_t'(wd_func);
            if (wr_ctrl)
                src <= wd_src;
            if (wr_ofs && ofs_ok)
                ofs <= $signed(wd);
            if (wr_scale)
                scale <= wd;
            if (wr_thr && thr_ok)
                thr <= wd;
            if (wr_hys && hys_ok)
                hys <= wd;
            if (wr_min)
                spd_min <= $signed(wd);
            if (wr_max)
                spd_max <= $signed(wd);
        end
    end

    // ==========================================================
    // Analog conditioning and speed demand
    wire signed [17:0] ain1_diff = $signed({2'b00, I_AIN1_LEVEL}) - 18'(ofs);
    wire signed [15:0] ain1_val = scale_sat(ain1_diff, scale);
    wire signed [15:0] slave_val = scale_sat($signed({2'b00, I_MASTER_SPEED}), scale);
    wire slave_mode = src == RSS_SRC_SLAVE;
    wire signed [15:0] dem_raw = slave_mode ? slave_val : ain1_val;
    wire signed [15:0] dem_val = clamp(dem_raw, spd_min, spd_max);

    // ==========================================================
    // Threshold flags: 0 frequency, 1 current, 2 analog input two
    logic [2:0] hi_flag;
    logic [1:0] lo_flag;
    wire [15:0] qty [3];
    assign qty[0] = I_OUT_FREQ;
    assign qty[1] = I_MOTOR_CURRENT;
    assign qty[2] = I_AIN2_LEVEL;

    always_ff @(posedge I_CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            hi_flag <= 3'h0;
            lo_flag <= 2'h0;
        end
        else
        begin
            for (int i = 0; i < 3; i++)
                hi_flag[i] <= upd_hi(hi_flag[i], qty[i], thr, hys);
            for (int i = 0; i < 2; i++)
                lo_flag[i] <= upd_lo(lo_flag[i], qty[i], thr, hys);
        end
    end

    // ==========================================================
    // Relay condition select
    logic cond;
    logic relay;

    always_comb
    begin
        case (func)
            RSS_F_RUN: cond = I_RUNNING;
            RSS_F_HEALTHY: cond = ~I_FAULT;
            RSS_F_AT_SPD: cond = I_OUT_FREQ == I_SETPOINT_FREQ;
            RSS_F_TRIP: cond = I_FAULT;
            RSS_F_SPD_HI: cond = hi_flag[0];
            RSS_F_CUR_HI: cond = hi_flag[1];
            RSS_F_SPD_LO: cond = lo_flag[0];
            RSS_F_CUR_LO: cond = lo_flag[1];
            RSS_F_AIN2_HI: cond = hi_flag[2];
            RSS_F_READY: cond = I_READY & ~I_FAULT;
            RSS_F_FIRE: cond = I_FIRE_MODE;
            RSS_F_SPD_NF: cond = hi_flag[0];
            RSS_F_BUS: cond = I_CTRL_WORD[RSS_CW_RELAY_BIT];
            default: cond = 1'b0;
        endcase
    end

    wire fire_hold = (func == RSS_F_SPD_NF) & I_FIRE_MODE;
    wire next_relay = fire_hold ? relay : cond;

    always_ff @(posedge I_CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            relay <= 1'b0;
            O_AIN1_VALUE <= 16'h0000;
            O_SPEED_DEMAND <= 16'h0000;
        end
        else
        begin
            relay <= next_relay;
            O_AIN1_VALUE <= ain1_val;
            O_SPEED_DEMAND <= dem_val;
        end
    end

    assign O_RELAY = relay;

    // ==========================================================
    // Read data
    wire [31:0] st_word = {25'h0, lo_flag, hi_flag, cond, relay};
    logic [31:0] rd_mux;

    always_comb
    begin
        case (I_AVS_ADDRESS)
            RSS_REG_CTRL: rd_mux = {24'h0, src, func};
            RSS_REG_OFS: rd_mux = {16'h0, ofs};
            RSS_REG_SCALE: rd_mux = {16'h0, scale};
            RSS_REG_THR: rd_mux = {16'h0, thr};
            RSS_REG_HYS: rd_mux = {16'h0, hys};
            RSS_REG_MIN: rd_mux = {16'h0, spd_min};
            RSS_REG_MAX: rd_mux = {16'h0, spd_max};
            RSS_REG_STAT: rd_mux = st_word;
            RSS_REG_AIN1: rd_mux = {16'h0, O_AIN1_VALUE};
            RSS_REG_DEM: rd_mux = {16'h0, O_SPEED_DEMAND};
            default: rd_mux = 32'h0;
        endcase
    end

    always_ff @(posedge I_CLK or negedge rst_n)
    begin
        if (!rst_n)
            O_AVS_READDATA <= 32'h0;
        else if (I_AVS_READ && !ack)
            O_AVS_READDATA <= rd_mux;
    end

    // ==========================================================
    // Assertions
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (!rst_n);

    sequence s_bus_wait;
        bus_req && O_AVS_WAITREQUEST;
    endsequence

    sequence s_thr_write;
        I_AVS_WRITE && !O_AVS_WAITREQUEST && I_AVS_ADDRESS == RSS_REG_THR && thr_ok;
    endsequence

    sequence s_over_thr;
        I_OUT_FREQ >= thr;
    endsequence

    property p_bus_ans;
        s_bus_wait |=> !O_AVS_WAITREQUEST;
    endproperty
    a_bus_ans: assert property (p_bus_ans) else $error("bus wait too long");

    property p_thr_wr;
        s_thr_write |=> thr == $past(I_AVS_WRITEDATA[15:0]);
    endproperty
    a_thr_wr: assert property (p_thr_wr) else $error("threshold not written");

    property p_ranges;
        func <= RSS_F_BUS && thr <= RSS_THR_MAX && hys <= RSS_HYS_MAX;
    endproperty
    a_ranges: assert property (p_ranges) else $error("setting out of range");

    property p_ofs;
        ofs >= RSS_OFS_MIN && ofs <= RSS_OFS_MAX;
    endproperty
    a_ofs: assert property (p_ofs) else $error("offset out of range");

    property p_run;
        func == RSS_F_RUN && I_RUNNING |=> O_RELAY;
    endproperty
    a_run: assert property (p_run) else $error("running relay off");

    property p_trip;
        func == RSS_F_TRIP ##1 func == RSS_F_TRIP |-> O_RELAY == $past(I_FAULT);
    endproperty
    a_trip: assert property (p_trip) else $error("trip relay wrong");

    property p_fire_hold;
        fire_hold |=> $stable(O_RELAY);
    endproperty
    a_fire_hold: assert property (p_fire_hold) else $error("relay moved in fire");

    property p_bus_bit;
        func == RSS_F_BUS |=> O_RELAY == $past(I_CTRL_WORD[RSS_CW_RELAY_BIT]);
    endproperty
    a_bus_bit: assert property (p_bus_bit) else $error("control bit not followed");

    property p_hi_set;
        s_over_thr ##1 func == RSS_F_SPD_HI |=> O_RELAY;
    endproperty
    a_hi_set: assert property (p_hi_set) else $error("speed flag not set");

    property p_slave;
        slave_mode && spd_min <= spd_max |=> $signed(O_SPEED_DEMAND) >= $past(spd_min)
            && $signed(O_SPEED_DEMAND) <= $past(spd_max);
    endproperty
    a_slave: assert property (p_slave) else $error("demand not clamped");

    property p_rst_off;
        $rose(rst_n) |-> !O_RELAY;
    endproperty
    a_rst_off: assert property (p_rst_off) else $error("relay on at reset");

endmodule : rss_relay_status_selector

`default_nettype wire

// ### rss_bus_model.sv
// Fieldbus master and relay contact model for the relay status selector bench
`timescale 1ns/1ns
`default_nettype none

// ==========================================================
// Far side model
module rss_bus_model
(
    input wire logic i_clk,
    input wire logic i_relay_cmd,
    input wire logic i_relay,
    output logic [15:0] o_ctrl_word,
    output logic o_contact_closed
);
    logic [7:0] cnt = 8'h00;
    logic cmd_q = 1'b0;
    always_ff @(posedge i_clk)
    begin
        cnt <= cnt + 8'h01;
        cmd_q <= i_relay_cmd;
    end
    // Other bits carry a free-running count, so a wrong bit index fails the bench except at 3, 4, 12 or 13
    assign o_ctrl_word = {cnt[6:0], cmd_q, cnt};
    // Terminals joined only while the coil is energised
    assign o_contact_closed = i_relay;
endmodule : rss_bus_model
`default_nettype wire

// ### rss_tb.sv
// Self-checking bench for the relay status selector
`timescale 1ns/1ns
`default_nettype none

module testbench
    import rss_pkg::*;
;
    // ==========================================================
    // Signals
    typedef struct packed {
        logic [3:0] func;
        logic [3:0] st;
        logic [15:0] freq;
        logic [15:0] cur;
        logic [15:0] ain2;
        logic cw;
        logic rel;
    } rss_row_t;
    typedef struct packed {
        logic [7:0] a;
        logic [31:0] d;
        logic [31:0] e;
    } rss_wr_t;
    localparam logic [15:0] T = 16'h03e8;
    localparam logic [15:0] B = 16'h03e7;
    localparam logic [15:0] H = 16'h04b0;
    localparam logic [15:0] Z = 16'h0000;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic waitreq;
    logic [15:0] ain1 = 16'h0;
    logic [15:0] ain2 = 16'h0;
    logic [15:0] freq = 16'h0;
    logic [15:0] cur = 16'h0;
    logic [15:0] master = 16'h0;
    logic [15:0] cword;
    logic [3:0] st = 4'h0;
    logic cw = 1'b0;
    logic relay;
    logic contact;
    logic [15:0] ain1_val;
    logic [15:0] demand;
    logic [15:0] setp = T;
    logic [31:0] q;
    int err_count = 0;
    int checks = 0;
    rss_row_t rows[25] = '{
        '{4'h0, 4'h8, Z, Z, Z, 1'b0, 1'b1}, '{4'h0, 4'h0, Z, Z, Z, 1'b0, 1'b0},
        '{4'h1, 4'h0, Z, Z, Z, 1'b0, 1'b1}, '{4'h1, 4'h4, Z, Z, Z, 1'b0, 1'b0},
        '{4'h2, 4'h0, T, Z, Z, 1'b0, 1'b1}, '{4'h2, 4'h0, B, Z, Z, 1'b0, 1'b0},
        '{4'h3, 4'h4, Z, Z, Z, 1'b0, 1'b1}, '{4'h3, 4'h0, Z, Z, Z, 1'b0, 1'b0},
        '{4'h4, 4'h0, T, Z, Z, 1'b0, 1'b1}, '{4'h4, 4'h0, B, Z, Z, 1'b0, 1'b0},
        '{4'h5, 4'h0, Z, H, Z, 1'b0, 1'b1}, '{4'h5, 4'h0, Z, B, Z, 1'b0, 1'b0},
        '{4'h6, 4'h0, B, Z, Z, 1'b0, 1'b1}, '{4'h6, 4'h0, T, Z, Z, 1'b0, 1'b0},
        '{4'h7, 4'h0, Z, B, Z, 1'b0, 1'b1}, '{4'h7, 4'h0, Z, T, Z, 1'b0, 1'b0},
        '{4'h8, 4'h0, Z, Z, T, 1'b0, 1'b1}, '{4'h8, 4'h0, Z, Z, B, 1'b0, 1'b0},
        '{4'h9, 4'h2, Z, Z, Z, 1'b0, 1'b1}, '{4'h9, 4'h6, Z, Z, Z, 1'b0, 1'b0},
        '{4'ha, 4'h1, Z, Z, Z, 1'b0, 1'b1}, '{4'ha, 4'h0, Z, Z, Z, 1'b0, 1'b0},
        '{4'hb, 4'h0, H, Z, Z, 1'b0, 1'b1},
        '{4'hc, 4'h0, Z, Z, Z, 1'b1, 1'b1}, '{4'hc, 4'h0, Z, Z, Z, 1'b0, 1'b0}};
    rss_wr_t regs[8] = '{
        '{RSS_REG_OFS, 32'h1389, 32'h0064}, '{RSS_REG_OFS, 32'hec78, 32'hec78},
        '{RSS_REG_THR, 32'h07d1, 32'h03e8}, '{RSS_REG_THR, 32'h07d0, 32'h07d0},
        '{RSS_REG_HYS, 32'h03e9, 32'h0064}, '{RSS_REG_HYS, 32'h03e8, 32'h03e8},
        '{RSS_REG_CTRL, 32'h000d, 32'h0004}, '{8'h30, 32'h1234, 32'h0000}};
    logic [31:0] dflt[7] = '{32'h1, 32'h0, 32'h3e8, 32'h3e8, 32'h0, 32'h0, 32'h3e8};
    logic [15:0] hf[6] = '{16'h03e8, 16'h03b6, 16'h0384, 16'h0383, 16'h03b6, 16'h03e8};
    logic he[6] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1};

    // ==========================================================
    // Clock, instances
    always #10 clk = ~clk;
    rss_relay_status_selector DUT (.I_CLK(clk), .I_ARST_N(arst_n), .I_AVS_ADDRESS(addr),
        .I_AVS_READ(rd), .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wdata), .O_AVS_READDATA(rdata),
        .O_AVS_WAITREQUEST(waitreq), .I_AIN1_LEVEL(ain1), .I_AIN2_LEVEL(ain2),
        .I_OUT_FREQ(freq), .I_SETPOINT_FREQ(setp), .I_MOTOR_CURRENT(cur),
        .I_MASTER_SPEED(master), .I_CTRL_WORD(cword), .I_RUNNING(st[3]), .I_FAULT(st[2]),
        .I_READY(st[1]), .I_FIRE_MODE(st[0]), .O_RELAY(relay), .O_AIN1_VALUE(ain1_val),
        .O_SPEED_DEMAND(demand));
    rss_bus_model u_bus (.i_clk(clk), .i_relay_cmd(cw), .i_relay(relay),
        .o_ctrl_word(cword), .o_contact_closed(contact));

    // ==========================================================
    // Tasks
    task automatic chk_bit(input logic got, input logic exp);
        checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_bit
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_word
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= w;
        rd <= !w;
        addr <= a;
        wdata <= d;
        // Waitrequest and read data are taken at the edge, before that edge updates them
        do
        begin
            @(posedge clk);
        end
        while (waitreq !== 1'b0);
        q = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask : bus
    task automatic settle();
        repeat (4) @(posedge clk);
        @(negedge clk);
    endtask : settle
    task automatic wrap_up();
        if (err_count == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : wrap_up

    // ==========================================================
    // Tests
    initial
    begin
        #200000;
        err_count++;
        wrap_up();
    end
    initial
    begin
        @(negedge clk);
        chk_bit(relay, 1'b0);
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        foreach (dflt[i])
        begin
            bus(1'b0, 8'(i * 4), 32'h0);
            chk_word(q, dflt[i]);
        end
        foreach (rows[i])
        begin
            bus(1'b1, RSS_REG_CTRL, {28'h0, rows[i].func});
            @(posedge clk);
            st <= rows[i].st;
            freq <= rows[i].freq;
            cur <= rows[i].cur;
            ain2 <= rows[i].ain2;
            cw <= rows[i].cw;
            settle();
            chk_bit(contact, rows[i].rel);
        end
        // Setpoint moved off its usual value so the match is not against a constant
        bus(1'b1, RSS_REG_CTRL, 32'h0002);
        @(posedge clk);
        freq <= B;
        setp <= B;
        settle();
        chk_bit(relay, 1'b1);
        // Hysteresis band 10.0 percent below the threshold on a rising flag
        bus(1'b1, RSS_REG_HYS, 32'h0064);
        bus(1'b1, RSS_REG_CTRL, 32'h0004);
        foreach (hf[i])
        begin
            @(posedge clk);
            freq <= hf[i];
            settle();
            chk_bit(relay, he[i]);
        end
        @(posedge clk);
        st <= 4'h1;
        bus(1'b1, RSS_REG_CTRL, 32'h000b);
        freq <= Z;
        settle();
        chk_bit(relay, 1'b1);
        @(posedge clk);
        st <= 4'h0;
        settle();
        chk_bit(relay, 1'b0);
        // Conditioning and demand
        bus(1'b1, RSS_REG_SCALE, 32'h07d0);
        ain1 <= 16'h01f4;
        settle();
        chk_word(ain1_val, 32'h03e8);
        bus(1'b1, RSS_REG_OFS, 32'h0064);
        ain1 <= 16'h0190;
        settle();
        chk_word(ain1_val, 32'h0258);
        chk_word(demand, 32'h0258);
        bus(1'b0, RSS_REG_AIN1, 32'h0);
        chk_word(q, 32'h0258);
        ain1 <= 16'h0032;
        settle();
        chk_word(ain1_val, 32'hff9c);
        chk_word(demand, 32'h0000);
        bus(1'b1, RSS_REG_CTRL, 32'h0094);
        master <= 16'h0320;
        settle();
        chk_word(demand, 32'h03e8);
        @(posedge clk);
        master <= 16'h012c;
        settle();
        chk_word(demand, 32'h0258);
        bus(1'b1, RSS_REG_MIN, 32'h02bc);
        settle();
        chk_word(demand, 32'h02bc);
        bus(1'b0, RSS_REG_DEM, 32'h0);
        chk_word(q, 32'h02bc);
        foreach (regs[i])
        begin
            bus(1'b1, regs[i].a, regs[i].d);
            bus(1'b0, regs[i].a, 32'h0);
            chk_word(q, regs[i].e);
        end
        // Reset in mid-run drops the relay at once
        bus(1'b1, RSS_REG_CTRL, 32'h0000);
        st <= 4'h8;
        settle();
        chk_bit(relay, 1'b1);
        @(posedge clk);
        arst_n <= 1'b0;
        @(negedge clk);
        chk_bit(relay, 1'b0);
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        bus(1'b0, RSS_REG_CTRL, 32'h0);
        chk_word(q, 32'h0001);
        wrap_up();
    end
endmodule : testbench
`default_nettype wire
